// ==== rtl/tcf_consts.vh ====
// Constants for the 16-bit timer capture and interrupt flag block
// Operation
// - Each capture event copies the 16-bit count into the capture latch; a low-byte write in the same cycle wins over it.
// - Capture latch serves as top value when waveform mode selects it.
// - 16-bit capture reads are atomic through a shared 8-bit high-byte latch; the high byte is parked a cycle after the low byte is sampled.
// - Capture request needs mask bit 5, global enable and capture flag.
// - Match B request needs mask bit 2, global enable and match B flag.
// - Match A request needs mask bit 1, global enable and match A flag.
// - Wrap request needs mask bit 0, global enable and wrap flag.
// - Capture flag, bit 5, sets on each pin capture event.
// - With capture latch as top, capture flag sets when count reaches top.
// - Capture flag clears on vector execution or on writing one.
// - Match B flag, bit 2, sets the timer cycle after count equals compare B.
// - Match A flag, bit 1, sets the timer cycle after count equals compare A.
// - Forced matches never set either compare flag.
// - Each compare flag clears on its vector execution or on writing one.
// - Wrap flag, bit 0, sets on overflow per mode table.
// - Wrap flag clears on vector execution or on writing one.
// - Falling pin edge captures when edge select is zero, rising when one.
// - Capture pin is ignored while capture latch is the top value.
// - A counter write blocks compare matches in the following timer cycle.
`ifndef TCF_CONSTS_VH
`define TCF_CONSTS_VH
`define TCF_ADDR_CAP_LOW 12'h000
`define TCF_ADDR_CAP_HIGH 12'h004
`define TCF_ADDR_MASK 12'h008
`define TCF_ADDR_FLAGS 12'h00c
`define TCF_ADDR_CTRL 12'h010
`define TCF_BIT_CAPTURE 5
`define TCF_BIT_MATCH_B 2
`define TCF_BIT_MATCH_A 1
`define TCF_BIT_WRAP 0
`define TCF_FLAG_USED 8'h27
`define TCF_CTRL_EDGE 0
`define TCF_CTRL_COMP 1
`define TCF_MODE_W 4
`define TCF_RESET_BYTE 8'h00
`endif

// ==== rtl/tcf_edge_detect.v ====
// Capture pin edge detector with selectable polarity
`timescale 1ns/1ns
module tcf_edge_detect (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Pin and select
	input wire pin_in,
	input wire rise_sel_in,
	input wire enable_in,
	// Event
	output wire edge_out
);
	reg prev_ff;
	reg primed_ff;
	// No edge until the pin has been sampled once, so reset gives no false edge
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_ff <= 1'b0;
			primed_ff <= 1'b0;
		end else begin
			prev_ff <= pin_in;
			primed_ff <= 1'b1;
		end
	end
	// Falling edge when select is zero, rising when one
	assign edge_out = enable_in & primed_ff &
		(rise_sel_in ? (pin_in & ~prev_ff) : (~pin_in & prev_ff));
endmodule // tcf_edge_detect

// ==== rtl/tcf_flag_bit.v ====
// One sticky interrupt flag with set-wins-over-clear and request gating
`timescale 1ns/1ns
module tcf_flag_bit (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Controls
	input wire set_in,
	input wire clear_in,
	input wire enable_in,
	input wire global_in,
	// Results
	output reg flag_out,
	output reg request_out
);
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flag_out <= 1'b0;
			request_out <= 1'b0;
		end else begin
			// Set wins over a clear arriving in the same cycle
			flag_out <= set_in | (flag_out & ~clear_in);
			request_out <= enable_in & global_in & (set_in | (flag_out & ~clear_in));
		end
	end
endmodule // tcf_flag_bit

// ==== rtl/tcf_capture_irq.v ====
// 16-bit timer capture latch, interrupt mask and flag logic with APB access
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "tcf_consts.vh"
module tcf_capture_irq #(
	parameter MODE_W = `TCF_MODE_W
) (
	// Clock and reset
	input wire REF_CLK_IN,
	input wire RST_IN,
	// APB slave
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	output reg [31:0] PRDATA_OUT,
	output reg PREADY_OUT,
	output reg PSLVERR_OUT,
	// Timer core
	input wire TIMER_TICK_IN,
	input wire [15:0] COUNT_VALUE_IN,
	input wire COUNT_WRITE_IN,
	input wire MATCH_A_IN,
	input wire MATCH_B_IN,
	input wire FORCE_MATCH_A_IN,
	input wire FORCE_MATCH_B_IN,
	input wire AT_TOP_IN,
	input wire WRAP_IN,
	input wire [MODE_W-1:0] WAVEFORM_MODE_FIELD_IN,
	// Capture sources
	input wire CAPTURE_PIN_IN,
	input wire COMPARATOR_IN,
	// Shared high-byte latch for other 16-bit registers
	input wire TEMP_LOAD_IN,
	input wire [7:0] TEMP_DATA_IN,
	output reg [7:0] TEMP_OUT,
	// Processor core
	input wire GLOBAL_IRQ_EN_IN,
	input wire CAPTURE_ACK_IN,
	input wire MATCH_A_ACK_IN,
	input wire MATCH_B_ACK_IN,
	input wire WRAP_ACK_IN,
	output reg CAPTURE_IRQ_OUT,
	output reg MATCH_A_IRQ_OUT,
	output reg MATCH_B_IRQ_OUT,
	output reg WRAP_IRQ_OUT,
	output reg [15:0] TOP_VALUE_OUT,
	output reg TOP_FROM_LATCH_OUT
);
	localparam [MODE_W-1:0] MODE_NORMAL = 4'd0;
	localparam [MODE_W-1:0] MODE_MATCH_CLR = 4'd4;
	localparam [MODE_W-1:0] MODE_PFC_LATCH = 4'd8;
	localparam [MODE_W-1:0] MODE_PC_LATCH = 4'd10;
	localparam [MODE_W-1:0] MODE_LATCH_CLR = 4'd12;
	localparam [MODE_W-1:0] MODE_FAST_LATCH = 4'd14;

	reg [15:0] capture_latch_ff;
	reg [7:0] capture_irq_mask_ff;
	reg edge_sel_ff;
	reg comp_sel_ff;
	reg block_match_ff;
	reg [7:0] temp_ff;
	wire top_is_latch;
	wire pin_edge;
	wire comp_edge;
	wire capture_event;
	wire access;
	wire wr_en;
	wire rd_en;
	wire mapped;
	wire [3:0] set_vec;
	wire [3:0] clr_vec;
	wire [3:0] ack_vec;
	wire [3:0] en_vec;
	wire [3:0] flag_vec;
	wire [3:0] req_vec;
	wire [7:0] flags_byte;
	wire match_ok;
	reg comp_prev_ff;
	reg [31:0] nxt_rdata;

	// Modes whose top value is the capture latch
	assign top_is_latch = (WAVEFORM_MODE_FIELD_IN == MODE_PFC_LATCH) |
		(WAVEFORM_MODE_FIELD_IN == MODE_PC_LATCH) |
		(WAVEFORM_MODE_FIELD_IN == MODE_LATCH_CLR) |
		(WAVEFORM_MODE_FIELD_IN == MODE_FAST_LATCH);

	tcf_edge_detect u_pin_edge (
		.clk_in(REF_CLK_IN),
		.rst_in(RST_IN),
		.pin_in(CAPTURE_PIN_IN),
		.rise_sel_in(edge_sel_ff),
		.enable_in(~top_is_latch & ~comp_sel_ff),
		.edge_out(pin_edge)
	);

	// Comparator source uses the same edge select
	always @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			comp_prev_ff <= 1'b0;
		end else begin
			comp_prev_ff <= COMPARATOR_IN;
		end
	end
	assign comp_edge = comp_sel_ff & ~top_is_latch &
		(edge_sel_ff ? (COMPARATOR_IN & ~comp_prev_ff) : (~COMPARATOR_IN & comp_prev_ff));
	assign capture_event = pin_edge | comp_edge;

	// APB decode
	assign access = PSEL_IN & PENABLE_IN & PREADY_OUT;
	assign mapped = (PADDR_IN == `TCF_ADDR_CAP_LOW) | (PADDR_IN == `TCF_ADDR_CAP_HIGH) |
		(PADDR_IN == `TCF_ADDR_MASK) | (PADDR_IN == `TCF_ADDR_FLAGS) |
		(PADDR_IN == `TCF_ADDR_CTRL);
	assign wr_en = access & PWRITE_IN & mapped;
	assign rd_en = access & ~PWRITE_IN & mapped;

	// Capture latch, shared high byte and control
	always @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			capture_latch_ff <= 16'h0000;
			temp_ff <= `TCF_RESET_BYTE;
			capture_irq_mask_ff <= `TCF_RESET_BYTE;
			edge_sel_ff <= 1'b0;
			comp_sel_ff <= 1'b0;
		end else begin
			if (wr_en && PADDR_IN == `TCF_ADDR_CAP_LOW) begin
				capture_latch_ff <= {temp_ff, PWDATA_IN[7:0]};
			end else if (capture_event) begin
				capture_latch_ff <= COUNT_VALUE_IN;
			end
			// Low-byte read parks the high byte; high write stages it
			if (rd_en && PADDR_IN == `TCF_ADDR_CAP_LOW) begin
				temp_ff <= capture_latch_ff[15:8];
			end else if (wr_en && PADDR_IN == `TCF_ADDR_CAP_HIGH) begin
				temp_ff <= PWDATA_IN[7:0];
			end else if (TEMP_LOAD_IN) begin
				temp_ff <= TEMP_DATA_IN;
			end
			if (wr_en && PADDR_IN == `TCF_ADDR_MASK) begin
				capture_irq_mask_ff <= PWDATA_IN[7:0] & `TCF_FLAG_USED;
			end
			if (wr_en && PADDR_IN == `TCF_ADDR_CTRL) begin
				edge_sel_ff <= PWDATA_IN[`TCF_CTRL_EDGE];
				comp_sel_ff <= PWDATA_IN[`TCF_CTRL_COMP];
			end
		end
	end

	// Counter write blocks matches in the next timer cycle
	always @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			block_match_ff <= 1'b0;
		end else if (COUNT_WRITE_IN) begin
			block_match_ff <= 1'b1;
		end else if (TIMER_TICK_IN) begin
			block_match_ff <= 1'b0;
		end
	end
	assign match_ok = TIMER_TICK_IN & ~block_match_ff & ~COUNT_WRITE_IN;

	// Flag sources; forced strobes are never inputs here
	assign set_vec[3] = capture_event | (top_is_latch & AT_TOP_IN & TIMER_TICK_IN);
	assign set_vec[2] = match_ok & MATCH_B_IN;
	assign set_vec[1] = match_ok & MATCH_A_IN;
	assign set_vec[0] = WRAP_IN & TIMER_TICK_IN;
	assign ack_vec = {CAPTURE_ACK_IN, MATCH_B_ACK_IN, MATCH_A_ACK_IN, WRAP_ACK_IN};
	assign en_vec = {capture_irq_mask_ff[`TCF_BIT_CAPTURE], capture_irq_mask_ff[`TCF_BIT_MATCH_B],
		capture_irq_mask_ff[`TCF_BIT_MATCH_A], capture_irq_mask_ff[`TCF_BIT_WRAP]};
	wire flag_wr;
	assign flag_wr = wr_en & (PADDR_IN == `TCF_ADDR_FLAGS);
	assign clr_vec[3] = ack_vec[3] | (flag_wr & PWDATA_IN[`TCF_BIT_CAPTURE]);
	assign clr_vec[2] = ack_vec[2] | (flag_wr & PWDATA_IN[`TCF_BIT_MATCH_B]);
	assign clr_vec[1] = ack_vec[1] | (flag_wr & PWDATA_IN[`TCF_BIT_MATCH_A]);
	assign clr_vec[0] = ack_vec[0] | (flag_wr & PWDATA_IN[`TCF_BIT_WRAP]);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
			tcf_flag_bit u_flag (
				.clk_in(REF_CLK_IN),
				.rst_in(RST_IN),
				.set_in(set_vec[gi]),
				.clear_in(clr_vec[gi]),
				.enable_in(en_vec[gi]),
				.global_in(GLOBAL_IRQ_EN_IN),
				.flag_out(flag_vec[gi]),
				.request_out(req_vec[gi])
			);
		end
	endgenerate

	assign flags_byte = {2'b00, flag_vec[3], 2'b00, flag_vec[2], flag_vec[1], flag_vec[0]};

	// Read mux
	always @* begin
		nxt_rdata = 32'h00000000;
		case (PADDR_IN)
			`TCF_ADDR_CAP_LOW: nxt_rdata = {24'h000000, capture_latch_ff[7:0]};
			`TCF_ADDR_CAP_HIGH: nxt_rdata = {24'h000000, temp_ff};
			`TCF_ADDR_MASK: nxt_rdata = {24'h000000, capture_irq_mask_ff};
			`TCF_ADDR_FLAGS: nxt_rdata = {24'h000000, flags_byte};
			`TCF_ADDR_CTRL: nxt_rdata = {30'h00000000, comp_sel_ff, edge_sel_ff};
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// APB answer: one wait cycle, ready for one cycle
	always @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			PREADY_OUT <= 1'b0;
			PRDATA_OUT <= 32'h00000000;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
			PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~mapped;
			if (PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~PWRITE_IN) begin
				PRDATA_OUT <= nxt_rdata;
			end
		end
	end

	// Registered core outputs
	always @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			CAPTURE_IRQ_OUT <= 1'b0;
			MATCH_B_IRQ_OUT <= 1'b0;
			MATCH_A_IRQ_OUT <= 1'b0;
			WRAP_IRQ_OUT <= 1'b0;
			TOP_VALUE_OUT <= 16'h0000;
			TOP_FROM_LATCH_OUT <= 1'b0;
			TEMP_OUT <= `TCF_RESET_BYTE;
		end else begin
			CAPTURE_IRQ_OUT <= req_vec[3];
			MATCH_B_IRQ_OUT <= req_vec[2];
			MATCH_A_IRQ_OUT <= req_vec[1];
			WRAP_IRQ_OUT <= req_vec[0];
			TOP_VALUE_OUT <= capture_latch_ff;
			TOP_FROM_LATCH_OUT <= top_is_latch;
			TEMP_OUT <= temp_ff;
		end
	end
endmodule // tcf_capture_irq

// ==== testbench/tcf_core_model.sv ====
// Core stand-in that executes the vector of each raised request
`timescale 1ns/1ns
module tcf_core_model (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Requests in, vector execution out
	input wire run_in,
	input wire [3:0] irq_in,
	output reg [3:0] ack_out
);
	reg [3:0] ack_d_ff;
	// One pulse per request; the request lags two cycles, so hold off two
	always @(posedge clk_in or posedge rst_in)
		if (rst_in) begin
			ack_out <= 4'h0;
			ack_d_ff <= 4'h0;
		end else begin
			ack_out <= irq_in & ~ack_out & ~ack_d_ff & {4{run_in}};
			ack_d_ff <= ack_out;
		end
endmodule // tcf_core_model

// ==== testbench/tcf_capture_irq_asserts.sv ====
// Port assertions for the capture and interrupt flag block
`timescale 1ns/1ns
module tcf_chk #(
	parameter MODE_W = 4
) (
	// Clock and reset
	input wire REF_CLK_IN, RST_IN,
	// Bus answer and timer inputs
	input wire PREADY_OUT, PSLVERR_OUT, TIMER_TICK_IN, MATCH_A_IN, WRAP_IN,
	input wire [MODE_W-1:0] WAVEFORM_MODE_FIELD_IN,
	// Core side
	input wire GLOBAL_IRQ_EN_IN, MATCH_A_ACK_IN, WRAP_ACK_IN, TOP_FROM_LATCH_OUT,
	input wire CAPTURE_IRQ_OUT, MATCH_A_IRQ_OUT, MATCH_B_IRQ_OUT, WRAP_IRQ_OUT
);
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (RST_IN);
	wire in_lat = WAVEFORM_MODE_FIELD_IN[3] & ~WAVEFORM_MODE_FIELD_IN[0];
	// Vector executed with no fresh cause in the same cycle
	sequence s_wrap_exec;
		WRAP_ACK_IN && !(WRAP_IN && TIMER_TICK_IN);
	endsequence
	sequence s_a_exec;
		MATCH_A_ACK_IN && !(MATCH_A_IN && TIMER_TICK_IN);
	endsequence
	chk_cap_global: assert property (CAPTURE_IRQ_OUT |-> $past(GLOBAL_IRQ_EN_IN, 2))
		else $error("capture request ungated");
	chk_b_global: assert property (MATCH_B_IRQ_OUT |-> $past(GLOBAL_IRQ_EN_IN, 2))
		else $error("match b request ungated");
	chk_a_global: assert property (MATCH_A_IRQ_OUT |-> $past(GLOBAL_IRQ_EN_IN, 2))
		else $error("match a request ungated");
	chk_wrap_global: assert property (WRAP_IRQ_OUT |-> $past(GLOBAL_IRQ_EN_IN, 2))
		else $error("wrap request ungated");
	chk_wrap_exec: assert property (s_wrap_exec |-> ##2 !WRAP_IRQ_OUT)
		else $error("wrap request outlives vector");
	chk_a_exec: assert property (s_a_exec |-> ##2 !MATCH_A_IRQ_OUT)
		else $error("match a request outlives vector");
	chk_top_latch: assert property (1'b1 |=> TOP_FROM_LATCH_OUT == $past(in_lat))
		else $error("top source decode wrong");
	chk_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("error without ready");
endmodule // tcf_chk
bind tcf_capture_irq tcf_chk #(.MODE_W(MODE_W)) u_chk (.*);

// ==== testbench/testbench.sv ====
// Self-checking bench for the capture and interrupt flag block
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %0t: %0h not %0h", $time, g, e); end end
module testbench;
	logic clk = 0, rst = 1, ps = 0, pe = 0, pw = 0, gl = 0, run = 0, err;
	logic [7:0] tim = 8'h80;
	logic [7:0] tbl [4] = '{8'h92, 8'hc2, 8'ha2, 8'h00};
	logic [11:0] pa = 0;
	logic [31:0] wd = 0, rd;
	logic [15:0] cnt = 0, v;
	logic [3:0] mode = 0;
	wire [31:0] prd;
	wire [15:0] tv;
	wire [7:0] tmp;
	wire [3:0] irq, ack;
	wire rdy, slv, tfl;
	int failures = 0, n_compared = 0, i, k;
	tcf_capture_irq u_dut (.REF_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(ps), .PENABLE_IN(pe),
		.PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(wd), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
		.PSLVERR_OUT(slv), .TIMER_TICK_IN(tim[1]), .COUNT_VALUE_IN(cnt), .COUNT_WRITE_IN(tim[0]),
		.MATCH_A_IN(tim[6]), .MATCH_B_IN(tim[5]), .FORCE_MATCH_A_IN(tim[3]),
		.FORCE_MATCH_B_IN(tim[3]), .AT_TOP_IN(tim[2]), .WRAP_IN(tim[4]),
		.WAVEFORM_MODE_FIELD_IN(mode), .CAPTURE_PIN_IN(tim[7]), .COMPARATOR_IN(1'b0),
		.TEMP_LOAD_IN(1'b0), .TEMP_DATA_IN(8'h00), .TEMP_OUT(tmp), .GLOBAL_IRQ_EN_IN(gl),
		.CAPTURE_ACK_IN(ack[3]), .MATCH_A_ACK_IN(ack[1]), .MATCH_B_ACK_IN(ack[2]),
		.WRAP_ACK_IN(ack[0]), .CAPTURE_IRQ_OUT(irq[3]), .MATCH_A_IRQ_OUT(irq[1]),
		.MATCH_B_IRQ_OUT(irq[2]), .WRAP_IRQ_OUT(irq[0]), .TOP_VALUE_OUT(tv),
		.TOP_FROM_LATCH_OUT(tfl));
	tcf_core_model u_core (.clk_in(clk), .rst_in(rst), .run_in(run), .irq_in(irq), .ack_out(ack));
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk) {ps, pw, pa, wd} <= {1'b1, w, a, d};
		@(posedge clk) pe <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (rdy !== 1'b1) failures++;
		{rd, err} = {prd, slv};
		{ps, pe} <= 2'b00;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd[7:0], e)
	endtask
	// Timer strobes for one cycle; a zero pattern also dips the pin low
	task automatic drv(input logic [7:0] s);
		@(posedge clk) tim <= s;
		@(posedge clk) tim <= 8'h80;
	endtask
	function automatic logic [7:0] fbit(int j);
		return 8'h01 << (j == 3 ? 5 : j);
	endfunction
	task automatic summarize();
		$display("compared %0d, mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		#200000;
		failures++;
		summarize();
	end
	initial begin
		void'($urandom(32'he94bc226));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdc(12'h008, 8'h00);
		rdc(12'h00c, 8'h00);
		rdc(12'h0f0, 8'h00);
		`CHK(err, 1'b1)
		apb(1'b1, 12'h008, 32'hff);
		rdc(12'h008, 8'h27);
		$display("test regs done");
		for (i = 0; i < 4; i++) begin
			apb(1'b1, 12'h008, {24'h0, fbit(i)});
			{gl, run} <= 2'b00;
			drv(tbl[i]);
			repeat (3) @(negedge clk);
			`CHK(irq, 4'h0)
			rdc(12'h00c, fbit(i));
			gl <= 1'b1;
			repeat (3) @(negedge clk);
			`CHK(irq, 4'h1 << i)
			@(posedge clk) run <= 1'b1;
			repeat (4) @(negedge clk);
			rdc(12'h00c, 8'h00);
		end
		$display("test sources done");
		apb(1'b1, 12'h008, 32'h0);
		drv(8'he2);
		apb(1'b1, 12'h00c, 32'h0);
		rdc(12'h00c, 8'h06);
		apb(1'b1, 12'h00c, 32'h2);
		rdc(12'h00c, 8'h04);
		drv(8'h8a);
		drv(8'h81);
		drv(8'hc2);
		rdc(12'h00c, 8'h04);
		apb(1'b1, 12'h00c, 32'h4);
		$display("test clears done");
		apb(1'b1, 12'h010, 32'h1);
		for (k = 0; k < 4; k++) begin
			v = 16'($urandom);
			cnt <= v;
			drv(8'h00);
			repeat (3) @(negedge clk);
			`CHK(tv, v)
			rdc(12'h000, v[7:0]);
			repeat (2) @(negedge clk);
			`CHK(tmp, v[15:8])
			cnt <= ~v;
			drv(8'h00);
			rdc(12'h004, v[15:8]);
		end
		$display("test capture done");
		apb(1'b1, 12'h00c, 32'h20);
		mode <= {1'b1, 2'($urandom), 1'b0};
		drv(8'h00);
		repeat (2) @(negedge clk);
		`CHK(tfl, 1'b1)
		`CHK(tv, ~v)
		rdc(12'h00c, 8'h00);
		drv(8'h86);
		rdc(12'h00c, 8'h20);
		$display("test top done");
		summarize();
	end
endmodule // testbench
